// ---- hdl/lighting_control.sv ----
/*
  lighting control: timebase select, flash sequencer, backlight codes, fade.
  assumes a 100 MHz clock, an asynchronous pin-level sync clock and trigger,
  and a master on the register port that never issues both strobes at once.
*/
`timescale 1ns/1ps
`default_nettype none
module lighting_control #(
  parameter int FLASH_UNIT_TICKS = lighting_pkg::FLASH_UNIT_TICKS,
  parameter int FADE_SLOW_TICKS  = lighting_pkg::FADE_SLOW_TICKS,
  parameter int FADE_FAST_TICKS  = lighting_pkg::FADE_FAST_TICKS
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] address,
  input  wire logic [7:0] writeData,
  input  wire logic       writeStrobe,
  input  wire logic       readStrobe,
  output logic      [7:0] readData,
  input  wire logic       syncClockPin,
  input  wire logic       flashTriggerPin,
  output logic            boostTick,
  output logic            rgbTick,
  output logic      [2:0] flashLevel,
  output logic      [7:0] mainSinkCode,
  output logic      [7:0] subSinkCode
);
  // refuse counts that the counters below cannot serve
  if (FLASH_UNIT_TICKS < 1) begin : gen_bad_flash_unit
    $error("lighting_control: flash unit ticks must be positive");
  end
  if (FADE_SLOW_TICKS < 1 || FADE_FAST_TICKS < 1) begin : gen_bad_fade_ticks
    $error("lighting_control: fade step ticks must be positive");
  end
  if (lighting_pkg::INT_DIV < 2 || lighting_pkg::INT_DIV > 256) begin : gen_bad_int_div
    $error("lighting_control: internal divider does not fit its counter");
  end
  if (lighting_pkg::RGB_DIV < 2 || lighting_pkg::RGB_DIV > 512) begin : gen_bad_rgb_div
    $error("lighting_control: rgb divider does not fit its counter");
  end

  typedef enum logic [2:0] {
    FL_OFF    = 3'b001,
    FL_VIEW   = 3'b010,
    FL_STROBE = 3'b100
  } flash_state_e;

  // one decode shared by every register write strobe
  function automatic logic regHit(input logic strobe, input logic [3:0] addr, input logic [3:0] offset);
    return strobe && addr == offset;
  endfunction

  logic [7:0]   control;
  logic [7:0]   flashReg;
  logic [7:0]   mainCode;
  logic [7:0]   subCode;
  logic [7:0]   fadeCode;
  logic [31:0]  fadeCount;
  logic [7:0]   intDiv;
  logic [8:0]   rgbDiv;
  logic [31:0]  flashCount;
  logic [1:0]   flashUnits;
  logic         syncMeta;
  logic         syncSafe;
  logic         syncLast;
  logic         trigMeta;
  logic         trigSafe;
  logic         trigLast;
  flash_state_e flashState;
  flash_state_e next_flashState;

  // synchronisers: first stage read only by the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      syncMeta <= 1'b0;
      syncSafe <= 1'b0;
      syncLast <= 1'b0;
      trigMeta <= 1'b0;
      trigSafe <= 1'b0;
      trigLast <= 1'b0;
    end else begin
      syncMeta <= syncClockPin;
      syncSafe <= syncMeta;
      syncLast <= syncSafe;
      trigMeta <= flashTriggerPin;
      trigSafe <= trigMeta;
      trigLast <= trigSafe;
    end
  end

  wire extSync    = control[lighting_pkg::CTL_EXT_SYNC];
  wire merge      = control[lighting_pkg::CTL_MERGE];
  wire fadeEnable = control[lighting_pkg::CTL_FADE_EN];
  wire fadeFast   = control[lighting_pkg::CTL_FADE_FAST];
  wire fadeSub    = control[lighting_pkg::CTL_FADE_SUB];
  wire flashOn    = flashReg[lighting_pkg::FL_ENABLE];
  wire [1:0] flashLvl = flashReg[lighting_pkg::FL_LEVEL_LSB +: 2];
  wire [1:0] flashDur = flashReg[lighting_pkg::FL_DUR_LSB +: 2];

  wire intTick = (intDiv == 8'(lighting_pkg::INT_DIV - 1));
  wire extTick = syncSafe & ~syncLast;
  // timebase for pattern, flash and fade timing only
  wire timeTick = extSync ? extTick : intTick;
  wire trigRise = trigSafe & ~trigLast;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      intDiv <= 8'h00;
    end else begin
      intDiv <= intTick ? 8'h00 : intDiv + 8'h01;
    end
  end
  assign boostTick = intTick;

  wire rgbWrap = (rgbDiv == 9'(lighting_pkg::RGB_DIV - 1));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rgbDiv  <= 9'h000;
      rgbTick <= 1'b0;
    end else begin
      rgbTick <= timeTick & rgbWrap;
      if (timeTick) begin
        rgbDiv <= rgbWrap ? 9'h000 : rgbDiv + 9'h001;
      end
    end
  end

  // register writes
  wire wrControl = regHit(writeStrobe, address, lighting_pkg::ADDR_CONTROL);
  wire wrFlash   = regHit(writeStrobe, address, lighting_pkg::ADDR_FLASH);
  wire wrMain    = regHit(writeStrobe, address, lighting_pkg::ADDR_MAIN_CODE);
  wire wrSub     = regHit(writeStrobe, address, lighting_pkg::ADDR_SUB_CODE);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control  <= lighting_pkg::RESET_CONTROL;
      flashReg <= lighting_pkg::RESET_FLASH;
      mainCode <= lighting_pkg::RESET_CODE;
      subCode  <= lighting_pkg::RESET_CODE;
    end else begin
      if (wrControl) control <= {3'h0, writeData[4:0]};
      if (wrFlash)   flashReg <= {3'h0, writeData[4:0]};
      if (wrMain)    mainCode <= writeData;
      if (wrSub)     subCode <= writeData;
    end
  end

  // flash sequencer
  wire [1:0] unitsNeeded = flashDur; // 0,1,2 extra units after the first
  wire unitDone = timeTick && flashCount == 32'(FLASH_UNIT_TICKS - 1);
  wire timedDone = unitDone && flashUnits == unitsNeeded;
  always_comb begin
    next_flashState = flashState;
    unique case (flashState)
      FL_OFF:    if (flashOn) next_flashState = FL_VIEW;
      FL_VIEW:   if (!flashOn) next_flashState = FL_OFF;
                 else if (trigRise) next_flashState = FL_STROBE;
      FL_STROBE: if (!flashOn) next_flashState = FL_OFF;
                 else if (flashDur == lighting_pkg::DUR_TRIGGER ? !trigSafe : timedDone)
                   next_flashState = FL_VIEW;
      default:   next_flashState = FL_OFF;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flashState <= FL_OFF;
      flashCount <= 32'h0;
      flashUnits <= 2'h0;
    end else begin
      flashState <= next_flashState;
      if (next_flashState != FL_STROBE || flashState != FL_STROBE) begin
        flashCount <= 32'h0;
        flashUnits <= 2'h0;
      end else if (timeTick) begin
        flashCount <= unitDone ? 32'h0 : flashCount + 32'h1;
        if (unitDone) flashUnits <= flashUnits + 2'h1;
      end
    end
  end

  // level: 1..4 quarters of maximum, 0 fully off
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flashLevel <= lighting_pkg::LEVEL_OFF;
    end else begin
      unique case (next_flashState)
        FL_VIEW:   flashLevel <= {1'b0, flashLvl} + 3'h1;
        FL_STROBE: flashLevel <= lighting_pkg::LEVEL_FULL;
        default:   flashLevel <= lighting_pkg::LEVEL_OFF;
      endcase
    end
  end

  // fade engine: tracks the selected bank's code one step at a time
  wire [7:0] fadeTarget = fadeSub ? subCode : mainCode;
  wire [31:0] stepTicks = fadeFast ? 32'(FADE_FAST_TICKS) : 32'(FADE_SLOW_TICKS);
  wire stepNow = timeTick && fadeCount >= stepTicks - 32'h1;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fadeCode  <= lighting_pkg::RESET_CODE;
      fadeCount <= 32'h0;
    end else if (!fadeEnable || fadeCode == fadeTarget) begin
      // follows target so the old code is the fade's start point
      if (!fadeEnable) fadeCode <= fadeTarget;
      fadeCount <= 32'h0;
    end else if (timeTick) begin
      fadeCount <= stepNow ? 32'h0 : fadeCount + 32'h1;
      if (stepNow)
        fadeCode <= (fadeCode < fadeTarget) ? fadeCode + 8'h01 : fadeCode - 8'h01;
    end
  end

  // fade applies only to its bank; others step at once
  wire [7:0] mainEff = (fadeEnable && !fadeSub) ? fadeCode : mainCode;
  wire [7:0] subEff  = (fadeEnable && fadeSub) ? fadeCode : subCode;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mainSinkCode <= lighting_pkg::RESET_CODE;
      subSinkCode  <= lighting_pkg::RESET_CODE;
    end else begin
      mainSinkCode <= mainEff;
      subSinkCode  <= merge ? mainEff : subEff;
    end
  end

  // read port
  logic [7:0] readMux;
  always_comb begin
    unique case (address)
      lighting_pkg::ADDR_CONTROL:   readMux = control;
      lighting_pkg::ADDR_FLASH:     readMux = flashReg;
      lighting_pkg::ADDR_MAIN_CODE: readMux = mainCode;
      lighting_pkg::ADDR_SUB_CODE:  readMux = subCode;
      lighting_pkg::ADDR_STATUS:    readMux = {4'h0, trigSafe, flashState};
      lighting_pkg::ADDR_EFFECTIVE: readMux = fadeCode;
      default:                      readMux = 8'h00;
    endcase
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readData <= 8'h00;
    end else begin
      readData <= readStrobe ? readMux : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/lighting_pkg.sv ----
/*
  constants for the lighting control block: register offsets, field positions,
  reset values and timing figures.
  assumes a 100 MHz system clock and a plain strobe register port.
*/
// Contract
// - sync select switches pattern/flash timing to external clock
// - external mode: durations scale with external clock
// - boost timing always from internal oscillator
// - 5MHz sync input yields 20 kHz RGB rate
// - flash enable 0 off, 1 on at level
// - current field selects quarter steps of maximum
// - enable write starts view-finder at selected level
// - trigger high starts full-current flash for duration
// - duration codes 200/400/600ms, 11 follows trigger
// - main and sub banks, 8-bit codes, 0.1mA steps
// - merge bit makes one code drive all six
// - fade enable ramps current, else immediate step
// - fade rate: 1.3s when 0, 0.65s when 1
// - fade bank: main when 0, sub when 1
package lighting_pkg;
  localparam logic [3:0] ADDR_CONTROL   = 4'h0;
  localparam logic [3:0] ADDR_FLASH     = 4'h1;
  localparam logic [3:0] ADDR_MAIN_CODE = 4'h2;
  localparam logic [3:0] ADDR_SUB_CODE  = 4'h3;
  localparam logic [3:0] ADDR_STATUS    = 4'h4;
  localparam logic [3:0] ADDR_EFFECTIVE = 4'h5;

  // control register bits
  localparam int CTL_EXT_SYNC   = 0;
  localparam int CTL_MERGE      = 1;
  localparam int CTL_FADE_EN    = 2;
  localparam int CTL_FADE_FAST  = 3;
  localparam int CTL_FADE_SUB   = 4;
  // flash register fields
  localparam int FL_ENABLE      = 0;
  localparam int FL_LEVEL_LSB   = 1;
  localparam int FL_DUR_LSB     = 3;

  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_FLASH   = 8'h00;
  localparam logic [7:0] RESET_CODE    = 8'h00;

  localparam logic [1:0] DUR_200MS   = 2'h0;
  localparam logic [1:0] DUR_400MS   = 2'h1;
  localparam logic [1:0] DUR_600MS   = 2'h2;
  localparam logic [1:0] DUR_TRIGGER = 2'h3;

  localparam logic [2:0] LEVEL_OFF  = 3'h0;
  localparam logic [2:0] LEVEL_FULL = 3'h4;

  // timing figures
  localparam int SYS_CLOCK_KHZ     = 100000;
  localparam int TIMEBASE_KHZ      = 5000;
  localparam int RGB_RATE_KHZ      = 20;
  localparam int FLASH_UNIT_MS     = 200;
  localparam int FADE_SLOW_MS      = 1300;
  localparam int FADE_FAST_MS      = 650;
  localparam int CODE_STEPS        = 255;
  // internal 5 MHz tick divider from system clock
  localparam int INT_DIV           = SYS_CLOCK_KHZ / TIMEBASE_KHZ;
  // timebase ticks per 20 kHz period
  localparam int RGB_DIV           = TIMEBASE_KHZ / RGB_RATE_KHZ;
  // timebase ticks per 200 ms flash unit
  localparam int FLASH_UNIT_TICKS  = FLASH_UNIT_MS * TIMEBASE_KHZ;
  // timebase ticks per fade step (longest time, rounded down)
  localparam int FADE_SLOW_TICKS   = FADE_SLOW_MS * TIMEBASE_KHZ / CODE_STEPS;
  localparam int FADE_FAST_TICKS   = FADE_FAST_MS * TIMEBASE_KHZ / CODE_STEPS;
endpackage

// ---- verif/flash_far_model.sv ----
/* far side: flash trigger source and external sync clock.
   sync clock runs only while syncRun is set. */
`timescale 1ns/1ps
`default_nettype none
module flash_far_model (
  input  wire logic clock,
  output var  logic syncClockPin,
  output var  logic flashTriggerPin
);
  logic syncRun = 1'b0;
  // half period: nominal 5 MHz, off the system clock grid; the bench may slow it
  real  syncHalf = 100.3;
  initial begin
    syncClockPin = 1'b0;
    flashTriggerPin = 1'b0;
  end
  always begin
    #syncHalf;
    syncClockPin = syncRun ? ~syncClockPin : 1'b0;
  end
  task automatic pulse(input int hold);
    @(posedge clock);
    flashTriggerPin <= 1'b1;
    repeat (hold) @(posedge clock);
    flashTriggerPin <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/lighting_control_sva.sv ----
/* port checker for lighting_control.
   bound to every instance; sees ports only. */
`timescale 1ns/1ps
`default_nettype none
module lighting_control_sva (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [3:0] address,
  input wire logic [7:0] writeData,
  input wire logic       writeStrobe,
  input wire logic       flashTriggerPin,
  input wire logic       boostTick,
  input wire logic       rgbTick,
  input wire logic [2:0] flashLevel,
  input wire logic [7:0] mainSinkCode,
  input wire logic [7:0] subSinkCode
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic      mergeOn;
  logic      fadeMain;
  wire logic wFl = writeStrobe && address == lighting_pkg::ADDR_FLASH;
  wire logic wCt = writeStrobe && address == lighting_pkg::ADDR_CONTROL;
  // control bits are not on the ports, so shadow them
  always_ff @(posedge clock or posedge rst)
    if (rst) {mergeOn, fadeMain} <= 2'h0;
    else if (wCt) {mergeOn, fadeMain} <= {writeData[1], writeData[2] & ~writeData[4]};
  sequence viewStart;
    wFl && writeData[0] && flashLevel == 3'h0;
  endsequence
  sequence trigInView;
    $rose(flashTriggerPin) && flashLevel inside {[3'h1:3'h3]};
  endsequence
  chk_boost_period: assert property (boostTick |-> ##20 boostTick)
    else $error("boost period wrong");
  chk_rgb_gap: assert property (rgbTick |=> !rgbTick [*8])
    else $error("rgb ticks too close");
  chk_level_max: assert property (flashLevel <= 3'h4)
    else $error("flash level too high");
  chk_flash_off: assert property (wFl && !writeData[0] |-> ##2 flashLevel == 3'h0)
    else $error("flash not off");
  chk_view_level: assert property (viewStart |-> ##2 flashLevel == 3'($past(writeData[2:1], 2)) + 3'h1)
    else $error("view level wrong");
  chk_strobe_start: assert property (trigInView |-> ##[2:8] flashLevel == 3'h4)
    else $error("flash did not start");
  chk_merge_follow: assert property (mergeOn && $past(mergeOn) |-> subSinkCode == mainSinkCode)
    else $error("sub not merged");
  chk_fade_step: assert property (fadeMain && $past(fadeMain) && $changed(mainSinkCode)
    |-> mainSinkCode - $past(mainSinkCode) inside {8'h01, 8'hff})
    else $error("fade step not one");
endmodule
bind lighting_control lighting_control_sva i_chk (.clock, .rst, .address, .writeData, .writeStrobe,
  .flashTriggerPin, .boostTick, .rgbTick, .flashLevel, .mainSinkCode, .subSinkCode);
`default_nettype wire

// ---- verif/test_lighting_control.sv ----
/* bench for lighting_control with short flash and fade counts.
   flash_far_model drives the trigger and sync pins. */
`timescale 1ns/1ps
`default_nettype none
module test_lighting_control;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic [7:0] writeData = 8'h00;
  logic       writeStrobe = 1'b0;
  logic       readStrobe = 1'b0;
  logic [7:0] readData, mainSinkCode, subSinkCode;
  logic [2:0] flashLevel;
  logic       boostTick, rgbTick, syncClockPin, flashTriggerPin;
  int         bad_count = 0;
  int         cmp_count = 0;
  int         n;
  always #5 clock = ~clock;
  lighting_control #(.FLASH_UNIT_TICKS(10), .FADE_SLOW_TICKS(2), .FADE_FAST_TICKS(1)) i_dut (.clock, .rst,
    .address, .writeData, .writeStrobe, .readStrobe, .readData, .syncClockPin, .flashTriggerPin,
    .boostTick, .rgbTick, .flashLevel, .mainSinkCode, .subSinkCode);
  flash_far_model i_far (.clock, .syncClockPin, .flashTriggerPin);
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    cmp_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 chk(readData, exp, exp);
  endtask
  function automatic logic [7:0] pick(input int s);
    return s == 0 ? 8'(flashLevel) : s == 1 ? mainSinkCode : s == 2 ? subSinkCode : 8'(boostTick);
  endfunction
  task automatic waitFor(input int s, input logic [7:0] want);
    for (n = 0; pick(s) !== want; n++) begin
      if (n == 30000) begin
        chk(n, 0, 0);
        end_of_test();
      end
      step();
    end
  endtask
  task automatic waitRgb();
    for (n = 0; rgbTick !== 1'b1; n++) begin
      if (n == 6000) begin
        chk(n, 0, 0);
        end_of_test();
      end
      step();
    end
  endtask
  // first timebase tick is partial, hence the tolerance
  task automatic flash(input logic [1:0] dur, input int hold, input int exp, input int tol);
    wr(lighting_pkg::ADDR_FLASH, {3'h0, dur, 3'h1});
    waitFor(0, 8'h01);
    fork
      i_far.pulse(hold);
    join_none
    waitFor(0, 8'h04);
    waitFor(0, 8'h01);
    chk(n, exp - tol, exp + tol);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    step();
    chk(mainSinkCode | subSinkCode | 8'(flashLevel), 0, 0);
    rd(lighting_pkg::ADDR_CONTROL, lighting_pkg::RESET_CONTROL);
    rd(4'hf, 8'h00);
    for (int l = 0; l < 4; l++) begin
      wr(lighting_pkg::ADDR_FLASH, 8'(2 * l + 1) | 8'he0);
      step();
      chk(8'(flashLevel), l + 1, l + 1);
      rd(lighting_pkg::ADDR_FLASH, 8'(2 * l + 1));
    end
    rd(lighting_pkg::ADDR_STATUS, 8'h02);
    wr(lighting_pkg::ADDR_FLASH, 8'h00);
    i_far.pulse(30);
    step();
    chk(8'(flashLevel), 0, 0);
    for (int d = 0; d < 3; d++) flash(2'(d), 5, 200 * d + 200, 25);
    flash(2'h3, 300, 300, 8);
    i_far.syncRun = 1'b1;
    wr(lighting_pkg::ADDR_CONTROL, 8'h01);
    step();
    waitRgb();
    step();
    waitRgb();
    chk(n + 1, 5013, 5017);
    waitFor(3, 8'h01);
    step();
    waitFor(3, 8'h01);
    chk(n + 1, 20, 20);
    // off nominal on purpose: flash length must follow the slower sync clock
    i_far.syncHalf = 200.3;
    flash(2'h0, 5, 400, 45);
    wr(lighting_pkg::ADDR_CONTROL, 8'h00);
    i_far.syncRun = 1'b0;
    waitRgb();
    step();
    waitRgb();
    chk(n + 1, 5000, 5000);
    wr(lighting_pkg::ADDR_MAIN_CODE, 8'hff);
    wr(lighting_pkg::ADDR_SUB_CODE, 8'h01);
    step();
    chk(mainSinkCode, 8'hff, 8'hff);
    chk(subSinkCode, 8'h01, 8'h01);
    rd(lighting_pkg::ADDR_MAIN_CODE, 8'hff);
    wr(lighting_pkg::ADDR_CONTROL, 8'h02);
    step();
    chk(subSinkCode, 8'hff, 8'hff);
    for (int k = 0; k < 4; k++) begin
      wr(lighting_pkg::ADDR_CONTROL, 8'h00);
      wr(lighting_pkg::ADDR_MAIN_CODE, 8'h10);
      wr(lighting_pkg::ADDR_SUB_CODE, 8'h10);
      wr(lighting_pkg::ADDR_CONTROL, 8'(k % 2 * 8));
      wr(lighting_pkg::ADDR_CONTROL, 8'(k * 8));
      wr(lighting_pkg::ADDR_CONTROL, 8'(k * 8 + 4));
      wr(lighting_pkg::ADDR_SUB_CODE - 4'(k / 2), 8'h20);
      step();
      chk(k > 1 ? mainSinkCode : subSinkCode, 8'h20, 8'h20);
      wr(lighting_pkg::ADDR_MAIN_CODE + 4'(k / 2), 8'h18);
      waitFor(1 + k / 2, 8'h18);
      chk(n, 320 / (k % 2 + 1) - 45, 320 / (k % 2 + 1) + 20);
    end
    rd(lighting_pkg::ADDR_EFFECTIVE, 8'h18);
    end_of_test();
  end
endmodule
`default_nettype wire
